// ---- include/rsd_map.svh ----
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH

// ----------------------------------------------------------------
// register word indices on the plain register port
// ----------------------------------------------------------------
`define RSD_REG_CTRL 4'h0
`define RSD_REG_SRC 4'h1
`define RSD_REG_ASSIGN 4'h2
`define RSD_REG_STAT 4'h3

// ----------------------------------------------------------------
// field positions (low bit of each field)
// ----------------------------------------------------------------
`define RSD_CTRL_SCHEME 0
`define RSD_CTRL_VARIANT 1
`define RSD_CTRL_PRIO 3
`define RSD_CTRL_IO 5
`define RSD_SRC_FL 0
`define RSD_SRC_REV 8
`define RSD_ASG_FWD 0
`define RSD_ASG_STOP 8

// ----------------------------------------------------------------
// source codes: 0 none, 1..8 and 11..16 physical inputs, 32..47 command bits
// ----------------------------------------------------------------
`define RSD_SRC_NONE 6'h00
`define RSD_SRC_UPPER 6'h08
`define RSD_SRC_EXT_LO 6'h0b
`define RSD_SRC_EXT_HI 6'h10
`define RSD_SRC_CMD_BASE 6'h20
`define RSD_SRC_CMD_ANY 6'h2b
`define RSD_SRC_CMD_HI 6'h2f

// ----------------------------------------------------------------
// factory assignments per wiring scheme
// ----------------------------------------------------------------
`define RSD_DEF_FWD_2W 6'h01
`define RSD_DEF_STOP_2W 6'h00
`define RSD_DEF_STOP_3W 6'h01
`define RSD_DEF_FWD_3W 6'h02

`endif

// ---- include/rsd_pkg.sv ----
`include "rsd_map.svh"

package rsd_pkg;

    // wiring scheme
    typedef enum logic {RSD_TWO_WIRE, RSD_THREE_WIRE} rsd_scheme_t;

    // 2-wire variants
    typedef enum logic [1:0] {RSD_LEVEL, RSD_EDGE, RSD_FWD_PRIO} rsd_variant_t;

    // terminal stop key priority
    typedef enum logic [1:0] {RSD_KEY_NONE, RSD_KEY_STOP, RSD_KEY_ALL} rsd_prio_t;

    // run state
    typedef enum logic [1:0] {RSD_IDLE, RSD_RUN, RSD_HELD} rsd_state_t;

    // software configuration carried as one word
    typedef struct packed {
        rsd_scheme_t scheme;
        rsd_variant_t variant;
        rsd_prio_t prio;
        logic io_profile;
        logic [5:0] fl_src;
        logic [5:0] rev_src;
        logic [5:0] fwd_src;
        logic [5:0] stop_src;
    } rsd_cfg_t;

    // is a source code selectable under the present hardware and profile
    function automatic logic rsd_src_ok(input logic [5:0] code, input logic allow_cmd,
                                        input logic io_prof, input logic upper,
                                        input logic ext);
        logic ok;
        ok = 1'b0;
        if (code == `RSD_SRC_NONE) begin
            ok = 1'b1;
        end else if (code < `RSD_SRC_UPPER) begin
            ok = 1'b1;
        end else if (code == `RSD_SRC_UPPER) begin
            ok = upper;
        end else if (code >= `RSD_SRC_EXT_LO && code <= `RSD_SRC_EXT_HI) begin
            ok = ext;
        end else if (code >= `RSD_SRC_CMD_BASE && code < `RSD_SRC_CMD_ANY) begin
            ok = allow_cmd & io_prof;
        end else if (code >= `RSD_SRC_CMD_ANY && code <= `RSD_SRC_CMD_HI) begin
            ok = allow_cmd;
        end
        return ok;
    endfunction

endpackage

// ---- core/rsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-stage level synchroniser, one per bit
module rsd_sync #(
    parameter int W = 19
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // refuse a vector the logic cannot hold
    if (W < 1) begin : g_bad_width
        $error("rsd_sync width must be at least one");
    end

    logic [W-1:0] meta_r; // first stage, read only by the second
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- core/rsd_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rsd_map.svh"

// picks one input bit by source code; unselectable codes read low
module rsd_sel (
    input wire logic [5:0] code,
    input wire logic [15:0] di,
    input wire logic [15:0] cmd,
    input wire logic allow_cmd,
    input wire logic io_profile,
    input wire logic upper_ok,
    input wire logic ext_ok,
    output logic val
);

    // decode; code 16 wraps to index 15
    always_comb begin
        val = 1'b0;
        if (rsd_pkg::rsd_src_ok(code, allow_cmd, io_profile, upper_ok, ext_ok)) begin
            if (code >= `RSD_SRC_CMD_BASE) begin
                val = cmd[code[3:0]];
            end else if (code != `RSD_SRC_NONE) begin
                val = di[code[3:0] - 4'h1];
            end
        end
    end

endmodule

`default_nettype wire

// ---- core/rsd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rsd_map.svh"

module rsd_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] di_pin,
    input wire logic [15:0] cmd_word,
    input wire logic stop_key_pin,
    input wire logic upper_present_pin,
    input wire logic ext_present_pin,
    input wire logic term_channel,
    input wire logic fault_state,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_r,
    output logic run_r,
    output logic reverse_r,
    output logic forced_local_r,
    output logic freewheel_r,
    output logic fault_reset_r
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [18:0] pins_s; // {ext, upper, key, di}
    logic [15:0] di_s;
    logic key_s;
    logic upper_s;
    logic ext_s;

    rsd_sync #(.W(19)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({ext_present_pin, upper_present_pin, stop_key_pin, di_pin}),
        .sync_out(pins_s)
    );

    assign di_s = pins_s[15:0];
    assign key_s = pins_s[16];
    assign upper_s = pins_s[17];
    assign ext_s = pins_s[18];

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    rsd_pkg::rsd_cfg_t cfg_r; // live configuration
    rsd_pkg::rsd_cfg_t cfg_nxt;
    logic scheme_chg; // scheme write that changes the scheme

    // write decode; illegal source codes leave the field unchanged
    always_comb begin
        cfg_nxt = cfg_r;
        scheme_chg = 1'b0;
        if (reg_wr && reg_addr == `RSD_REG_CTRL) begin
            cfg_nxt.prio = rsd_pkg::rsd_prio_t'(reg_wdata[`RSD_CTRL_PRIO +: 2]);
            cfg_nxt.io_profile = reg_wdata[`RSD_CTRL_IO];
            if (reg_wdata[`RSD_CTRL_SCHEME] != cfg_r.scheme) begin
                // rewiring: drop to factory assignments for the new scheme
                scheme_chg = 1'b1;
                cfg_nxt.scheme = rsd_pkg::rsd_scheme_t'(reg_wdata[`RSD_CTRL_SCHEME]);
                cfg_nxt.variant = rsd_pkg::RSD_EDGE;
                cfg_nxt.rev_src = `RSD_SRC_NONE;
                if (reg_wdata[`RSD_CTRL_SCHEME]) begin
                    cfg_nxt.fwd_src = `RSD_DEF_FWD_3W;
                    cfg_nxt.stop_src = `RSD_DEF_STOP_3W;
                end else begin
                    cfg_nxt.fwd_src = `RSD_DEF_FWD_2W;
                    cfg_nxt.stop_src = `RSD_DEF_STOP_2W;
                end
            end else if (cfg_r.scheme == rsd_pkg::RSD_TWO_WIRE) begin
                // variant only reachable under 2-wire; code 3 is refused
                if (reg_wdata[`RSD_CTRL_VARIANT +: 2] != 2'h3) begin
                    cfg_nxt.variant =
                        rsd_pkg::rsd_variant_t'(reg_wdata[`RSD_CTRL_VARIANT +: 2]);
                end
            end
        end
        if (reg_wr && reg_addr == `RSD_REG_SRC) begin
            // forced local takes physical inputs only
            if (rsd_pkg::rsd_src_ok(reg_wdata[`RSD_SRC_FL +: 6], 1'b0,
                                    cfg_r.io_profile, upper_s, ext_s)) begin
                cfg_nxt.fl_src = reg_wdata[`RSD_SRC_FL +: 6];
            end
            // reverse also takes command word bits
            if (rsd_pkg::rsd_src_ok(reg_wdata[`RSD_SRC_REV +: 6], 1'b1,
                                    cfg_r.io_profile, upper_s, ext_s)) begin
                cfg_nxt.rev_src = reg_wdata[`RSD_SRC_REV +: 6];
            end
        end
        if (reg_wr && reg_addr == `RSD_REG_ASSIGN) begin
            if (rsd_pkg::rsd_src_ok(reg_wdata[`RSD_ASG_FWD +: 6], 1'b0,
                                    cfg_r.io_profile, upper_s, ext_s)) begin
                cfg_nxt.fwd_src = reg_wdata[`RSD_ASG_FWD +: 6];
            end
            if (rsd_pkg::rsd_src_ok(reg_wdata[`RSD_ASG_STOP +: 6], 1'b0,
                                    cfg_r.io_profile, upper_s, ext_s)) begin
                cfg_nxt.stop_src = reg_wdata[`RSD_ASG_STOP +: 6];
            end
        end
        // io profile holds forced local unassigned, also against writes
        if (cfg_nxt.io_profile) begin
            cfg_nxt.fl_src = `RSD_SRC_NONE;
        end
    end

    // configuration registers; reset is the factory 2-wire edge setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r.scheme <= rsd_pkg::RSD_TWO_WIRE;
            cfg_r.variant <= rsd_pkg::RSD_EDGE;
            cfg_r.prio <= rsd_pkg::RSD_KEY_STOP;
            cfg_r.io_profile <= 1'b0;
            cfg_r.fl_src <= `RSD_SRC_NONE;
            cfg_r.rev_src <= `RSD_SRC_NONE;
            cfg_r.fwd_src <= `RSD_DEF_FWD_2W;
            cfg_r.stop_src <= `RSD_DEF_STOP_2W;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ----------------------------------------------------------------
    // source selectors: forced local, reverse, forward, stop
    // ----------------------------------------------------------------
    logic [5:0] sel_code [4];
    logic [3:0] sel_val; // {stop, fwd, rev, fl}

    assign sel_code[0] = cfg_r.fl_src;
    assign sel_code[1] = cfg_r.rev_src;
    assign sel_code[2] = cfg_r.fwd_src;
    assign sel_code[3] = cfg_r.stop_src;

    // only the reverse selector may reach command word bits
    for (genvar g = 0; g < 4; g++) begin : g_sel
        rsd_sel u_sel (
            .code(sel_code[g]),
            .di(di_s),
            .cmd(cmd_word),
            .allow_cmd(g == 1),
            .io_profile(cfg_r.io_profile),
            .upper_ok(upper_s),
            .ext_ok(ext_s),
            .val(sel_val[g])
        );
    end

    // ----------------------------------------------------------------
    // run / stop decoding
    // ----------------------------------------------------------------
    rsd_pkg::rsd_state_t state_r; // run state
    rsd_pkg::rsd_state_t state_nxt;
    logic [2:0] prev_r; // previous {stop, fwd, rev}
    logic [2:0] prev_nxt;
    logic key_r; // previous key level
    logic primed_r; // synced pins valid and one sample held in prev_r
    logic [1:0] prime_r; // fills as the pin synchroniser fills after reset
    logic reverse_nxt;
    logic forced_local_nxt;
    logic freewheel_nxt;
    logic fault_reset_nxt;
    logic rev_in;
    logic fwd_in;
    logic stp_in;
    logic cmd_any;
    logic cmd_was;
    logic key_press;
    logic key_stop;
    logic rev_dir;

    // next state of the decoder
    always_comb begin
        rev_in = sel_val[1];
        fwd_in = sel_val[2];
        stp_in = sel_val[3];
        cmd_any = fwd_in | rev_in;
        cmd_was = prev_r[1] | prev_r[0];
        prev_nxt = {stp_in, fwd_in, rev_in};
        key_press = key_s & ~key_r;
        // off-terminal key obeys the priority setting
        key_stop = key_press &
                   (term_channel | (cfg_r.prio != rsd_pkg::RSD_KEY_NONE));
        fault_reset_nxt = key_press & fault_state &
                          (term_channel | (cfg_r.prio == rsd_pkg::RSD_KEY_ALL));
        // reverse level chooses rotation unless forward has priority
        rev_dir = rev_in &
                  ~(fwd_in & (cfg_r.variant == rsd_pkg::RSD_FWD_PRIO));
        forced_local_nxt = sel_val[0];
        state_nxt = state_r;
        reverse_nxt = reverse_r;
        freewheel_nxt = freewheel_r;
        // default-priority key off terminal stops in freewheel
        if (key_stop && !term_channel && cfg_r.prio == rsd_pkg::RSD_KEY_STOP) begin
            freewheel_nxt = 1'b1;
        end
        if (scheme_chg) begin
            // a rewire never carries a run over
            state_nxt = rsd_pkg::RSD_IDLE;
        end else if (cfg_r.scheme == rsd_pkg::RSD_THREE_WIRE) begin
            case (state_r)
                rsd_pkg::RSD_RUN: begin
                    // stop pulse wins over a start pulse in the same cycle
                    if ((stp_in && !prev_r[2]) || key_stop) begin
                        state_nxt = rsd_pkg::RSD_IDLE;
                    end else if (fwd_in && !prev_r[1]) begin
                        reverse_nxt = 1'b0;
                    end else if (rev_in && !prev_r[0]) begin
                        reverse_nxt = 1'b1;
                    end
                end
                default: begin
                    if (primed_r && !(stp_in && !prev_r[2]) && !key_stop) begin
                        if (fwd_in && !prev_r[1]) begin
                            state_nxt = rsd_pkg::RSD_RUN;
                            reverse_nxt = 1'b0;
                        end else if (rev_in && !prev_r[0]) begin
                            state_nxt = rsd_pkg::RSD_RUN;
                            reverse_nxt = 1'b1;
                        end
                    end
                end
            endcase
        end else if (cfg_r.variant == rsd_pkg::RSD_EDGE) begin
            case (state_r)
                rsd_pkg::RSD_RUN: begin
                    reverse_nxt = rev_dir;
                    // falling command or a stopping key press (key_stop) stops
                    if ((!cmd_any && cmd_was) || key_stop) begin
                        state_nxt = rsd_pkg::RSD_IDLE;
                    end
                end
                default: begin
                    // a level already high at power-up is not an edge
                    if (primed_r && cmd_any && !cmd_was && !key_stop) begin
                        state_nxt = rsd_pkg::RSD_RUN;
                        reverse_nxt = rev_dir;
                    end
                end
            endcase
        end else begin
            case (state_r)
                rsd_pkg::RSD_RUN: begin
                    reverse_nxt = rev_dir;
                    if (!cmd_any) begin
                        state_nxt = rsd_pkg::RSD_IDLE;
                    end else if (key_stop) begin
                        // priority all off terminal: stop, then restart on held level
                        if (!term_channel && cfg_r.prio == rsd_pkg::RSD_KEY_ALL) begin
                            state_nxt = rsd_pkg::RSD_IDLE;
                        end else begin
                            state_nxt = rsd_pkg::RSD_HELD;
                        end
                    end
                end
                rsd_pkg::RSD_HELD: begin
                    // stays stopped until the run level is dropped
                    if (!cmd_any) begin
                        state_nxt = rsd_pkg::RSD_IDLE;
                    end
                end
                default: begin
                    if (cmd_any && !key_stop) begin
                        state_nxt = rsd_pkg::RSD_RUN;
                        reverse_nxt = rev_dir;
                    end
                end
            endcase
        end
        // a fresh start clears the freewheel mark
        if (state_nxt == rsd_pkg::RSD_RUN && state_r != rsd_pkg::RSD_RUN) begin
            freewheel_nxt = 1'b0;
        end
    end

    // decoder registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= rsd_pkg::RSD_IDLE;
            prev_r <= 3'h0;
            key_r <= 1'b0;
            primed_r <= 1'b0;
            prime_r <= 2'h0;
            run_r <= 1'b0;
            reverse_r <= 1'b0;
            forced_local_r <= 1'b0;
            freewheel_r <= 1'b0;
            fault_reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            prev_r <= prev_nxt;
            key_r <= key_s;
            // synced pins read reset zeros for two edges; arming earlier
            // would see a level held at power-up as a fresh rising edge
            prime_r <= {prime_r[0], 1'b1};
            primed_r <= prime_r[1];
            run_r <= (state_nxt == rsd_pkg::RSD_RUN);
            reverse_r <= reverse_nxt;
            forced_local_r <= forced_local_nxt;
            freewheel_r <= freewheel_nxt;
            fault_reset_r <= fault_reset_nxt;
        end
    end

    // ----------------------------------------------------------------
    // register read port; data valid the cycle after the strobe only
    // ----------------------------------------------------------------
    logic [15:0] rdata_nxt;

    // read mux; unmapped words and idle cycles read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `RSD_REG_CTRL: begin
                    rdata_nxt = {10'h000, cfg_r.io_profile, cfg_r.prio,
                                 cfg_r.variant, cfg_r.scheme};
                end
                `RSD_REG_SRC: begin
                    rdata_nxt = {2'h0, cfg_r.rev_src, 2'h0, cfg_r.fl_src};
                end
                `RSD_REG_ASSIGN: begin
                    rdata_nxt = {2'h0, cfg_r.stop_src, 2'h0, cfg_r.fwd_src};
                end
                `RSD_REG_STAT: begin
                    rdata_nxt = {10'h000, state_r == rsd_pkg::RSD_HELD, freewheel_r,
                                 forced_local_r, reverse_r, run_r, primed_r};
                end
                default: begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- tb/rsd_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// port-level checker for the run/stop decoder
// ----------------------------------------------------------------
module rsd_top_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] di_pin,
    input wire logic [15:0] cmd_word,
    input wire logic stop_key_pin,
    input wire logic fault_state,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_r,
    input wire logic run_r,
    input wire logic reverse_r,
    input wire logic forced_local_r,
    input wire logic freewheel_r,
    input wire logic fault_reset_r
);
    // one clock domain, so one default for all properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0)
        else $error("read data not zero outside read cycle");
    chk_stat_image: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3 |->
        reg_rdata_r[4:1] == $past({freewheel_r, forced_local_r, reverse_r, run_r}))
        else $error("status word does not mirror outputs");
    chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h3 |->
        reg_rdata_r == 16'h0)
        else $error("unmapped read not zero");
    // forced local only ever rises from a physical input
    chk_fl_cause: assert property ($rose(forced_local_r) |-> $past(di_pin, 3) != 16'h0)
        else $error("forced local without an input");
    // a start needs some live command source
    chk_run_cause: assert property ($rose(run_r) |->
        ($past(di_pin, 3) != 16'h0) || ($past(cmd_word) != 16'h0))
        else $error("run without a command");
    chk_fault_pulse: assert property (fault_reset_r |=> !fault_reset_r)
        else $error("fault reset longer than one cycle");
    chk_fault_cause: assert property (fault_reset_r |->
        $past(fault_state) && $past(stop_key_pin, 3))
        else $error("fault reset without key in fault");
    chk_freewheel_stop: assert property (freewheel_r |-> !run_r)
        else $error("freewheel flag while running");
endmodule

bind rsd_top rsd_top_monitor u_rsd_top_monitor (
    .mclk(mclk),
    .rst_n(rst_n),
    .di_pin(di_pin),
    .cmd_word(cmd_word),
    .stop_key_pin(stop_key_pin),
    .fault_state(fault_state),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r),
    .run_r(run_r),
    .reverse_r(reverse_r),
    .forced_local_r(forced_local_r),
    .freewheel_r(freewheel_r),
    .fault_reset_r(fault_reset_r)
);

`default_nettype wire

// ---- tb/rsd_pins.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// wired switches and terminal key on the far side
// ----------------------------------------------------------------
module rsd_pins (
    input wire logic mclk,
    input wire logic [15:0] sw,
    input wire logic key_req,
    output logic [15:0] di_pin,
    output logic stop_key_pin
);
    logic [2:0] hold_r = 3'h0; // key press length left

    // contacts settle one cycle late; a key press lasts four cycles
    always_ff @(posedge mclk) begin
        di_pin <= sw;
        if (key_req) begin
            hold_r <= 3'h4;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end
    end
    assign stop_key_pin = (hold_r != 3'h0);
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] sw = 16'h1; // run level already up at power-on
    logic [15:0] cmd_word = 16'h0;
    logic key_req = 1'b0;
    logic fault_state = 1'b0;
    logic term = 1'b0; // terminal is the active command channel
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fr_seen = 1'b0; // latched fault reset pulse
    wire logic [15:0] di_pin, reg_rdata_r;
    wire logic stop_key_pin, run_r, reverse_r, forced_local_r, freewheel_r, fault_reset_r;
    int err_total = 0;
    int cmp_count = 0;

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (fault_reset_r) fr_seen <= 1'b1;

    rsd_pins u_rsd_pins (.mclk(mclk), .sw(sw), .key_req(key_req), .di_pin(di_pin),
        .stop_key_pin(stop_key_pin));
    // no upper input, no extension
    rsd_top u_rsd_top (.mclk(mclk), .rst_n(rst_n), .di_pin(di_pin), .cmd_word(cmd_word),
        .stop_key_pin(stop_key_pin), .upper_present_pin(1'b0), .ext_present_pin(1'b0),
        .term_channel(term), .fault_state(fault_state), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .run_r(run_r), .reverse_r(reverse_r), .forced_local_r(forced_local_r),
        .freewheel_r(freewheel_r), .fault_reset_r(fault_reset_r));

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ckb(input logic g, input logic e);
        cmp({15'h0, g}, {15'h0, e});
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata_r, e);
    endtask
    task automatic press();
        @(posedge mclk);
        key_req <= 1'b1;
        @(posedge mclk);
        key_req <= 1'b0;
        tick(8);
    endtask
    task automatic drive(input logic [15:0] v);
        @(posedge mclk);
        sw <= v;
        tick(6);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults();
        rd(4'h0, 16'h000a);
        rd(4'h2, 16'h0001);
        rd(4'h1, 16'h0000);
        rd(4'hf, 16'h0000);
        rd(4'h3, 16'h0001);
    endtask
    // held level at power-up must not start; a fresh edge does
    task automatic t_edge();
        ckb(run_r, 1'b0);
        drive(16'h0);
        drive(16'h1);
        ckb(run_r, 1'b1);
        ckb(reverse_r, 1'b0);
        drive(16'h0);
        ckb(run_r, 1'b0);
    endtask
    task automatic t_level();
        wr(4'h1, 16'h0200);
        wr(4'h0, 16'h0008);
        drive(16'h1);
        ckb(run_r, 1'b1);
        drive(16'h3);
        ckb(reverse_r, 1'b1);
        wr(4'h0, 16'h000c);
        tick(2);
        ckb(reverse_r, 1'b0);
        drive(16'h0);
        ckb(run_r, 1'b0);
    endtask
    task automatic t_key();
        wr(4'h0, 16'h0000);
        drive(16'h1);
        press();
        ckb(run_r, 1'b1);
        @(posedge mclk);
        term <= 1'b1;
        press();
        ckb(run_r, 1'b0);
        @(posedge mclk);
        term <= 1'b0;
        drive(16'h0);
        drive(16'h1);
        wr(4'h0, 16'h0008);
        @(posedge mclk);
        fault_state <= 1'b1;
        fr_seen <= 1'b0;
        press();
        ckb(run_r, 1'b0);
        ckb(freewheel_r, 1'b1);
        ckb(fr_seen, 1'b0);
        wr(4'h0, 16'h0010);
        drive(16'h0);
        drive(16'h1);
        press();
        ckb(run_r, 1'b1);
        ckb(fr_seen, 1'b1);
        @(posedge mclk);
        fault_state <= 1'b0;
        drive(16'h0);
    endtask
    task automatic t_sources();
        wr(4'h0, 16'h0008);
        wr(4'h1, 16'h0203);
        drive(16'h4);
        ckb(forced_local_r, 1'b1);
        drive(16'h0);
        ckb(forced_local_r, 1'b0);
        wr(4'h1, 16'h0208);
        rd(4'h1, 16'h0203);
        wr(4'h0, 16'h0028);
        rd(4'h1, 16'h0200);
        wr(4'h1, 16'h2100);
        rd(4'h1, 16'h2100);
        wr(4'h0, 16'h0008);
        wr(4'h1, 16'h2b00);
        wr(4'h1, 16'h2100);
        rd(4'h1, 16'h2b00);
        @(posedge mclk);
        cmd_word <= 16'h0800;
        drive(16'h1);
        ckb(reverse_r, 1'b1);
        @(posedge mclk);
        cmd_word <= 16'h0;
        drive(16'h0);
    endtask
    task automatic t_three();
        wr(4'h0, 16'h0001);
        rd(4'h0, 16'h0003);
        rd(4'h2, 16'h0102);
        rd(4'h1, 16'h0000);
        wr(4'h0, 16'h0005);
        rd(4'h0, 16'h0003);
        drive(16'h2);
        drive(16'h0);
        ckb(run_r, 1'b1);
        drive(16'h1);
        drive(16'h0);
        ckb(run_r, 1'b0);
    endtask

    task automatic results();
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard: all scenarios need well under 1000 cycles
    initial begin
        #50000;
        err_total++;
        results();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        tick(8);
        t_defaults();
        t_edge();
        t_level();
        t_key();
        t_sources();
        t_three();
        results();
    end
endmodule

`default_nettype wire
